// >>> hdl/qt_query_slice.v
// qt_query_slice: apb slave presenting the read-capability slice of the query table,
// plus the read configuration it steers and a status view of the decoded capabilities.
// assumes an apb master on pclk; one wait state on every transfer.
`timescale 1ns/1ns
`include "qt_defines.vh"

// Notes on behaviour
// - the page capability entry at query index 4c reads 03, an eight byte page.
// - the page capability byte is an exponent n and the page holds two to the n bytes.
// - a page capability of zero means no page buffer, so page mode stays off.
// - query index 4d reads 04, four burst capability fields follow it.
// - a burst field count of zero means no burst capability, so only plain reads run.
// - a burst field holds n in bits 0 to 2 and the burst is two to the n plus one words.
// - burst code 07 means continuous linear bursting to the end of the burstable space.
// - query index 4e reads 01, a four word burst.
// - query index 4f reads 02, an eight word burst.
// - query index 50 reads 03, a sixteen word burst.
// - query index 51 reads 07, continuous burst.
// - query index 52 reads the number of hardware partition regions.
// - a partition region count of zero marks a single partition device.
// - a nonzero partition region count gives the number of regions.
module qt_query_slice #(
  parameter [7:0] PART_REGIONS = `QT_PREG_DEF,
  parameter CNT_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  output reg query_mode_q,
  output reg page_mode_en_q,
  output reg burst_mode_en_q,
  output reg [2:0] burst_len_code_q
);

  // software held state
  reg ctrl_q;
  reg [4:0] rcfg_q;
  reg [31:0] status_q;
  reg [31:0] status_d;
  reg [CNT_W-1:0] qcnt_q;

  // bus phase decode
  wire setup_ph;
  wire access_ph;
  wire done_ph;
  wire [`QT_IDX_W-1:0] idx;
  wire own_hit;
  wire tbl_hit;

  // table read port
  wire [7:0] rom_data;
  wire rom_hit;

  // decoded capability lengths
  wire [15:0] page_bytes;
  wire [15:0] burst_words;

  // configuration checks
  reg code_ok;
  wire [2:0] cfg_code;
  wire cont_sel;
  wire page_ok;
  wire burst_ok;
  wire single_part;

  // response assembly
  reg [31:0] rdata_d;
  reg err_d;

  // apb phases: setup starts the table lookup, done is the sampling edge
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable & ~pready_q;
  assign done_ph = psel & penable & pready_q;
  assign idx = paddr[11:2];

  // own control, configuration, status and counter words
  assign own_hit = (idx == `QT_IDX_CTRL) | (idx == `QT_IDX_RCFG) |
                   (idx == `QT_IDX_STAT) | (idx == `QT_IDX_CNT);

  // the query slice spans index 4c to 52 inclusive
  assign tbl_hit = (idx >= `QT_IDX_PAGE) & (idx <= `QT_IDX_PREG);

  // table bytes come out of a register one cycle after setup
  // region count passes unchanged
  qt_rom #(
    .PART_REGIONS(PART_REGIONS)
  ) u_rom (
    .pclk(pclk),
    .presetn(presetn),
    .rd_en(setup_ph),
    .rd_idx(idx),
    .rd_data_q(rom_data),
    .rd_hit_q(rom_hit)
  );

  qt_pow2 #(
    .OUT_W(16)
  ) u_page_len (
    .exp_code(`QT_PAGE_CODE),
    .bias(`QT_PAGE_BIAS),
    .size(page_bytes)
  );

  // burst words from n plus one
  qt_pow2 #(
    .OUT_W(16)
  ) u_burst_len (
    .exp_code({5'h00, cfg_code}),
    .bias(`QT_BURST_BIAS),
    .size(burst_words)
  );

  // code field in bits 0 to 2
  assign cfg_code = rcfg_q[`QT_RCFG_CODE_HI:`QT_RCFG_CODE_LO];

  assign cont_sel = (cfg_code == `QT_BURST_CONT);

  // the configured code must match one of the advertised burst fields
  always @* begin
    code_ok = 1'b0;
    if (cfg_code == `QT_BC1_CODE) begin
      code_ok = 1'b1;
    end
    if (cfg_code == `QT_BC2_CODE) begin
      code_ok = 1'b1;
    end
    if (cfg_code == `QT_BC3_CODE) begin
      code_ok = 1'b1;
    end
    if (cfg_code == `QT_BC4_CODE) begin
      code_ok = 1'b1;
    end
  end

  assign page_ok = rcfg_q[`QT_RCFG_PEN] & (`QT_PAGE_CODE != 8'h00);

  assign burst_ok = rcfg_q[`QT_RCFG_BEN] & (`QT_BCNT_CODE != 8'h00) & code_ok;

  assign single_part = (PART_REGIONS == 8'h00);

  // status word: capability decode and current mode
  always @* begin
    status_d = 32'h0000_0000;
    status_d[`QT_ST_PAGE_OK] = page_ok;
    status_d[`QT_ST_BURST_OK] = burst_ok;
    status_d[`QT_ST_CODE_OK] = code_ok;
    status_d[`QT_ST_CONT] = cont_sel;
    status_d[`QT_ST_SINGLE] = single_part;
    status_d[`QT_ST_QMODE] = ctrl_q;
    status_d[`QT_ST_PBYTES_HI:`QT_ST_PBYTES_LO] = page_bytes[7:0];
    if (cont_sel) begin
      status_d[`QT_ST_BWORDS_HI:`QT_ST_BWORDS_LO] = 16'hffff;
    end else begin
      status_d[`QT_ST_BWORDS_HI:`QT_ST_BWORDS_LO] = burst_words;
    end
  end

  // status is sampled every cycle so reads see a settled value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 32'h0000_0000;
    end else begin
      status_q <= status_d;
    end
  end

  // read data and error for the current access
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (tbl_hit) begin
      // table is read only; a write is refused
      err_d = pwrite;
      if (!pwrite && ctrl_q && rom_hit) begin
        rdata_d = {24'h000000, rom_data};
      end
    end else if (own_hit) begin
      // status refuses writes; a counter write is taken only as a counter clear
      err_d = pwrite & (idx == `QT_IDX_STAT);
      if (!pwrite) begin
        case (idx)
          `QT_IDX_CTRL: rdata_d = {31'h0000_0000, ctrl_q};
          `QT_IDX_RCFG: rdata_d = {27'h0000_000, rcfg_q};
          `QT_IDX_STAT: rdata_d = status_q;
          `QT_IDX_CNT: rdata_d = {{(32-CNT_W){1'b0}}, qcnt_q};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end else begin
      // unmapped address answers with an error and zero data
      err_d = 1'b1;
    end
  end

  // one wait state: ready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (access_ph) begin
      prdata_q <= rdata_d;
      pready_q <= 1'b1;
      pslverr_q <= err_d;
    end else begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // writes land on the edge that samples ready; byte lane 0 carries every field
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `QT_CTRL_RST;
      rcfg_q <= `QT_RCFG_RST;
    end else if (done_ph && pwrite && pstrb[0]) begin
      if (idx == `QT_IDX_CTRL) begin
        ctrl_q <= pwdata[`QT_CTRL_QMODE];
      end
      if (idx == `QT_IDX_RCFG) begin
        rcfg_q <= pwdata[4:0];
      end
    end
  end

  // count of completed table reads in query mode; any write to it clears it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_q <= {CNT_W{1'b0}};
    end else if (done_ph && pwrite && (idx == `QT_IDX_CNT)) begin
      qcnt_q <= {CNT_W{1'b0}};
    end else if (done_ph && !pwrite && tbl_hit && ctrl_q) begin
      qcnt_q <= qcnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // mode outputs toward the read path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      query_mode_q <= 1'b0;
      page_mode_en_q <= 1'b0;
      burst_mode_en_q <= 1'b0;
      burst_len_code_q <= `QT_BURST_CONT;
    end else begin
      query_mode_q <= ctrl_q;
      page_mode_en_q <= page_ok;
      burst_mode_en_q <= burst_ok;
      burst_len_code_q <= cfg_code;
    end
  end

  // the table entry at index 52 carries PART_REGIONS as is; nonzero counts are regions

endmodule // qt_query_slice

// >>> hdl/qt_defines.vh
// qt_defines.vh: register indices, table codes, field positions and reset values
// for the query table read slice; included by qt_query_slice and qt_rom, definitions only.
`ifndef QT_DEFINES_VH
`define QT_DEFINES_VH

// register indices; the byte address on the bus is index * 4
`define QT_IDX_W 10
`define QT_IDX_CTRL 10'h000
`define QT_IDX_RCFG 10'h001
`define QT_IDX_STAT 10'h002
`define QT_IDX_CNT 10'h003
`define QT_IDX_PAGE 10'h04c
`define QT_IDX_BCNT 10'h04d
`define QT_IDX_BC1 10'h04e
`define QT_IDX_BC2 10'h04f
`define QT_IDX_BC3 10'h050
`define QT_IDX_BC4 10'h051
`define QT_IDX_PREG 10'h052

// query table codes
`define QT_PAGE_CODE 8'h03
`define QT_BCNT_CODE 8'h04
`define QT_BC1_CODE 8'h01
`define QT_BC2_CODE 8'h02
`define QT_BC3_CODE 8'h03
`define QT_BC4_CODE 8'h07
`define QT_PREG_DEF 8'h01
`define QT_BURST_CONT 3'h7
`define QT_PAGE_BIAS 8'h00
`define QT_BURST_BIAS 8'h01

// control register fields
`define QT_CTRL_QMODE 0
`define QT_CTRL_RST 1'h0

// read configuration register fields
`define QT_RCFG_CODE_HI 2
`define QT_RCFG_CODE_LO 0
`define QT_RCFG_BEN 3
`define QT_RCFG_PEN 4
`define QT_RCFG_RST 5'h07

// status register fields
`define QT_ST_PAGE_OK 0
`define QT_ST_BURST_OK 1
`define QT_ST_CODE_OK 2
`define QT_ST_CONT 3
`define QT_ST_SINGLE 4
`define QT_ST_QMODE 5
`define QT_ST_PBYTES_HI 15
`define QT_ST_PBYTES_LO 8
`define QT_ST_BWORDS_HI 31
`define QT_ST_BWORDS_LO 16

`endif

// >>> hdl/qt_pow2.v
// qt_pow2: turns an exponent code plus a bias into a power-of-two length.
// assumes a combinational caller; saturates to all ones when the size will not fit.
`timescale 1ns/1ns

module qt_pow2 #(
  parameter OUT_W = 16
) (
  input wire [7:0] exp_code,
  input wire [7:0] bias,
  output wire [OUT_W-1:0] size
);

  localparam [8:0] LIMIT = OUT_W;
  localparam [OUT_W-1:0] ONE = {{(OUT_W-1){1'b0}}, 1'b1};

  wire [8:0] exp_sum;

  // exponent plus bias, one bit wider so it never wraps
  assign exp_sum = {1'b0, exp_code} + {1'b0, bias};
  assign size = (exp_sum >= LIMIT) ? {OUT_W{1'b1}} : (ONE << exp_sum);

endmodule // qt_pow2

// >>> hdl/qt_rom.v
// qt_rom: the fixed query table bytes, read through an output register.
// assumes rd_en is a one-cycle strobe from the bus side in the pclk domain.
`timescale 1ns/1ns
`include "qt_defines.vh"

module qt_rom #(
  parameter [7:0] PART_REGIONS = `QT_PREG_DEF
) (
  input wire pclk,
  input wire presetn,
  input wire rd_en,
  input wire [`QT_IDX_W-1:0] rd_idx,
  output reg [7:0] rd_data_q,
  output reg rd_hit_q
);

  // registered table lookup; misses read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_q <= 8'h00;
      rd_hit_q <= 1'b0;
    end else if (rd_en) begin
      rd_hit_q <= 1'b1;
      case (rd_idx)
        `QT_IDX_PAGE: rd_data_q <= `QT_PAGE_CODE;
        `QT_IDX_BCNT: rd_data_q <= `QT_BCNT_CODE;
        `QT_IDX_BC1: rd_data_q <= `QT_BC1_CODE;
        `QT_IDX_BC2: rd_data_q <= `QT_BC2_CODE;
        `QT_IDX_BC3: rd_data_q <= `QT_BC3_CODE;
        `QT_IDX_BC4: rd_data_q <= `QT_BC4_CODE;
        `QT_IDX_PREG: rd_data_q <= PART_REGIONS;
        default: begin
          rd_data_q <= 8'h00;
          rd_hit_q <= 1'b0;
        end
      endcase
    end
  end

endmodule // qt_rom

// >>> dv/qt_query_slice_properties.sv
// qt_props: port-level assertions for the query table slice.
// assumes a bind onto qt_query_slice; single pclk domain, async active-low reset.
`timescale 1ns/1ns
module qt_props #(
  parameter [7:0] PART_REGIONS = 8'h01,
  parameter CNT_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata_q,
  input wire pready_q,
  input wire pslverr_q,
  input wire query_mode_q,
  input wire page_mode_en_q,
  input wire burst_mode_en_q,
  input wire [2:0] burst_len_code_q
);
  // completed table read in query mode
  wire [9:0] idx = paddr[11:2];
  wire rd = psel && penable && !pwrite && pready_q && query_mode_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_wait_a: assert property (psel && !penable |=> !pready_q ##1 pready_q)
    else $error("ready not in second access cycle");
  page_code_a: assert property (rd && idx == 10'h04c |-> prdata_q == 32'h3)
    else $error("page capability wrong");
  burst_count_a: assert property (rd && idx == 10'h04d |-> prdata_q == 32'h4)
    else $error("burst field count wrong");
  four_word_a: assert property (rd && idx == 10'h04e |-> prdata_q == 32'h1)
    else $error("first burst field wrong");
  eight_word_a: assert property (rd && idx == 10'h04f |-> prdata_q == 32'h2)
    else $error("second burst field wrong");
  sixteen_word_a: assert property (rd && idx == 10'h050 |-> prdata_q == 32'h3)
    else $error("third burst field wrong");
  cont_burst_a: assert property (rd && idx == 10'h051 |-> prdata_q == 32'h7)
    else $error("fourth burst field wrong");
  part_count_a: assert property (rd && idx == 10'h052 |-> prdata_q[7:0] == PART_REGIONS)
    else $error("partition count wrong");
  upper_zero_a: assert property (pready_q && !pwrite && idx >= 10'h04c && idx <= 10'h052
    |-> prdata_q[31:8] == 24'h0) else $error("upper table bits not zero");
endmodule // qt_props

// >>> dv/qt_apb_host.sv
// qt_apb_host: apb master standing for the host controller.
// assumes pclk from the bench; xfer is called from the bench's main sequence.
`timescale 1ns/1ns
module qt_apb_host (
  input wire pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire [31:0] prdata_q,
  input wire pready_q,
  input wire pslverr_q
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
  end
  // one transfer: setup, access held until ready, then release
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rdat, output logic err);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait for ready however long it takes; the bench watchdog ends a hang
      do begin
        @(posedge pclk);
      end while (pready_q !== 1'b1);
      rdat = prdata_q;
      err = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // released data no longer shows the last value
    end
  endtask
endmodule // qt_apb_host

// >>> dv/tb_query_table_read_burst_caps.sv
// tb_query_table_read_burst_caps: self-checking bench for the query table slice.
// assumes qt_apb_host drives the bus and qt_props is bound below.
`timescale 1ns/1ns
module tb_query_table_read_burst_caps;
  localparam [7:0] PART_REGIONS = 8'h01;
  localparam CNT_W = 16;
  logic pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q, er, ok;
  logic query_mode_q, page_mode_en_q, burst_mode_en_q;
  logic [2:0] burst_len_code_q, c;
  logic [1:0] en;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata_q, rd, d, ex;
  int bad_count, n_checks, k, nrd, seed;
  qt_query_slice #(.PART_REGIONS(PART_REGIONS), .CNT_W(CNT_W)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .query_mode_q(query_mode_q), .page_mode_en_q(page_mode_en_q),
    .burst_mode_en_q(burst_mode_en_q), .burst_len_code_q(burst_len_code_q));
  qt_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q));
  // table contents expected at each index
  function automatic logic [31:0] exp_tbl(input int i);
    case (i)
      'h4c: exp_tbl = 32'h3;
      'h4d: exp_tbl = 32'h4;
      'h4e: exp_tbl = 32'h1;
      'h4f: exp_tbl = 32'h2;
      'h50: exp_tbl = 32'h3;
      'h51: exp_tbl = 32'h7;
      default: exp_tbl = {24'h0, PART_REGIONS};
    endcase
  endfunction
  // compare one value and count it
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_checks++;
      if (g !== e) begin
        bad_count++;
        $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    conclude;
  end
  // main sequence
  initial begin
    seed = 32'h6ddc28f2;
    presetn = 1'b0;
    nrd = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rcfg reset", 32'h7, {29'h0, burst_len_code_q});
    host.xfer(1'b0, 12'h130, 32'h0, rd, er);
    chk("table outside query", 32'h0, rd);
    host.xfer(1'b1, 12'h000, 32'h1, rd, er);
    for (k = 'h4c; k <= 'h52; k++) begin
      host.xfer(1'b0, 12'(k * 4), 32'h0, rd, er);
      nrd++;
      chk("table", exp_tbl(k), rd);
      chk("table err", 32'h0, {31'h0, er});
    end
    chk("query mode", 32'h1, {31'h0, query_mode_q});
    host.xfer(1'b1, 12'h134, $random(seed), rd, er);
    chk("ro write err", 32'h1, {31'h0, er});
    host.xfer(1'b0, 12'h134, 32'h0, rd, er);
    nrd++;
    chk("table kept", 32'h4, rd);
    host.xfer(1'b0, 12'h200 + 12'(({$random(seed)} % 64) * 4), 32'h0, rd, er);
    chk("unmapped", 32'h8000_0000, {er, rd[30:0]});
    // burst codes from the table first, then random codes
    for (k = 0; k < 14; k++) begin
      d = $random(seed);
      c = d[2:0];
      if (k < 4) begin
        host.xfer(1'b0, 12'h138 + 12'(k * 4), 32'h0, rd, er);
        nrd++;
        c = rd[2:0];
      end
      // page and burst requests on for the table codes, random afterwards
      en = (k < 4) ? 2'b11 : d[4:3];
      host.xfer(1'b1, 12'h004, {d[31:5], en, c}, rd, er);
      host.xfer(1'b0, 12'h008, 32'h0, rd, er);
      ok = (c == 3'h1 || c == 3'h2 || c == 3'h3 || c == 3'h7);
      ex = {(c == 3'h7) ? 16'hffff : 16'(1 << (c + 1)), 8'h08, 3'b001,
        PART_REGIONS == 8'h0, c == 3'h7, ok, en[0] & ok, en[1]};
      chk("status", ex, rd);
      chk("burst code", {29'h0, c}, {29'h0, burst_len_code_q});
      chk("burst enable", {31'h0, en[0] & ok}, {31'h0, burst_mode_en_q});
      chk("page enable", {31'h0, en[1]}, {31'h0, page_mode_en_q});
    end
    host.xfer(1'b0, 12'h00c, 32'h0, rd, er);
    chk("read count", 32'(nrd), rd);
    conclude;
  end
endmodule // tb_query_table_read_burst_caps
bind qt_query_slice qt_props #(.PART_REGIONS(PART_REGIONS), .CNT_W(CNT_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q), .pready_q(pready_q),
  .pslverr_q(pslverr_q), .query_mode_q(query_mode_q), .page_mode_en_q(page_mode_en_q),
  .burst_mode_en_q(burst_mode_en_q), .burst_len_code_q(burst_len_code_q));
